// File: fbg_pkg.sv
// Package with the constants, field layouts and state carriers of the flash boot partition guard.
package fbg_pkg;
  localparam int unsigned FBG_PC_W = 15;
  localparam int unsigned FBG_Z_W = 16;
  localparam int unsigned FBG_PAGE_W = 8;
  localparam int unsigned FBG_WORD_W = 7;
  localparam int unsigned FBG_Z_PAGE_LSB = 8;
  localparam int unsigned FBG_Z_WORD_LSB = 1;
  localparam int unsigned FBG_Z_BYTE_SEL = 0;
  localparam int unsigned FBG_LOCK_W = 6;
  localparam int unsigned FBG_IDX_W = 6;
  localparam logic [FBG_PC_W-1:0] FBG_BOOT_START_11 = 15'h7E00;
  localparam logic [FBG_PC_W-1:0] FBG_BOOT_START_10 = 15'h7C00;
  localparam logic [FBG_PC_W-1:0] FBG_BOOT_START_01 = 15'h7800;
  localparam logic [FBG_PC_W-1:0] FBG_BOOT_START_00 = 15'h7000;
  localparam logic [FBG_PC_W-1:0] FBG_FLASH_TOP = 15'h7FFF;
  localparam logic [FBG_PC_W-1:0] FBG_EXCL_LO = 15'h3800;
  localparam logic [FBG_PC_W-1:0] FBG_EXCL_HI = 15'h3FFF;
  localparam logic [31:0] FBG_OFS_CFG = 32'h0000_0000;
  localparam logic [31:0] FBG_OFS_LOCK = 32'h0000_0004;
  localparam logic [31:0] FBG_OFS_ERASE = 32'h0000_0008;
  localparam logic [31:0] FBG_OFS_STAT = 32'h0000_000C;
  localparam int unsigned FBG_CFG_SZ_LO = 0;
  localparam int unsigned FBG_CFG_SZ_HI = 1;
  localparam int unsigned FBG_CFG_IVSEL = 2;
  localparam int unsigned FBG_ERASE_GO = 0;
  localparam int unsigned FBG_LK_GEN_LO = 0;
  localparam int unsigned FBG_LK_GEN_HI = 1;
  localparam int unsigned FBG_LK_APP_WR = 2;
  localparam int unsigned FBG_LK_APP_RD = 3;
  localparam int unsigned FBG_LK_BOOT_WR = 4;
  localparam int unsigned FBG_LK_BOOT_RD = 5;
  localparam logic [1:0] FBG_LK_UNUSED = 2'h3;
  localparam logic [FBG_LOCK_W-1:0] FBG_LOCK_RST = 6'h3F;
  localparam logic [1:0] FBG_BOOTSZ_RST = 2'h0;
  localparam logic FBG_IVSEL_RST = 1'b0;
  localparam logic [7:0] FBG_BLOCKED_BYTE = 8'hFF;

  typedef struct packed {
    logic [1:0] bootsz;
    logic ivsel;
    logic wr_pend;
    logic [FBG_IDX_W-1:0] wr_idx;
    logic [31:0] rdata;
    logic spm_done;
    logic spm_ok;
    logic [FBG_PAGE_W-1:0] page;
    logic [FBG_WORD_W-1:0] word;
    logic excl;
    logic lpm_done;
    logic [7:0] lpm_byte;
    logic irq_off;
  } fbg_main_s;

  typedef struct packed {
    logic [FBG_LOCK_W-1:0] lock;
  } fbg_lock_s;
endpackage : fbg_pkg

// File: fbg_lock_store.sv
// Nonvolatile lock bit store: programming only clears bits, chip erase sets them all.
`timescale 1ns/10ps
module fbg_lock_store (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_prog_we,
  input wire logic [fbg_pkg::FBG_LOCK_W-1:0] i_prog_data,
  input wire logic i_boot_frozen,
  input wire logic i_chip_erase,
  output logic [fbg_pkg::FBG_LOCK_W-1:0] o_lock
);
  import fbg_pkg::*;
  fbg_lock_s s_r;
  fbg_lock_s s_nxt;
  logic [FBG_LOCK_W-1:0] keep;

  always_comb begin
    s_nxt = s_r;
    keep = '0;
    if (i_chip_erase) begin
      s_nxt.lock = FBG_LOCK_RST;
    end else if (i_prog_we) begin
      // Application and boot guard bits, 5:2, stay as they are while both general bits are programmed.
      keep[FBG_LK_BOOT_RD:FBG_LK_APP_WR] = {4{i_boot_frozen}};
      s_nxt.lock = s_r.lock & (i_prog_data | keep);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{lock: FBG_LOCK_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_lock = s_r.lock;

  lock_no_raise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !$past(i_chip_erase) |-> ((o_lock & ~$past(o_lock)) == '0)) else $error("lock bit returned to 1 without erase");
  lock_erase_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_chip_erase |=> o_lock == FBG_LOCK_RST) else $error("chip erase left a lock bit programmed");
endmodule : fbg_lock_store

// File: fbg_guard.sv
// Boot partition decode, self-programming address split and lock bit protection with an AHB-Lite slave.
//
// Operation
// - Boot size from two size bits: 512, 1024, 2048 or 4096 words.
// - Boot section ends at 0x7FFF; its start is the boot reset address.
// - All boundaries and sizes count 16-bit words.
// - 0x3800-0x3FFF is the exclusive region, below and above it the concurrent region.
// - Program counter is 15 bits; its top bit maps to pointer bit 15.
// - Pages hold 128 words; word in page is pointer bits 7 to 1.
// - Page erase and write take the page from pointer bits 15 to 8.
// - Pointer bit 0 is zero for stores and selects the byte for loads.
// - Six lock bits, 1 unprogrammed, 0 programmed, reset to unprogrammed.
// - Only chip erase returns lock bits to 1.
// - Lock byte: boot pair 5:4, application pair 3:2, general pair 1:0, 7:6 read 1.
// - General bits both unprogrammed put no limit on the programmer.
// - General low bit programmed stops programming and fuse changes, keeps verify.
// - Both general bits programmed stop verify too and freeze boot lock bits.
// - Application write guard blocks stores into the application section.
// - Application read guard blocks loads from boot code into application section.
// - With it, vectors in boot section mask interrupts while running application code.
// - Boot write guard blocks stores into the boot section.
// - Boot read guard blocks loads from application code into boot section.
// - With it, vectors in application section mask interrupts while running boot code.
`timescale 1ns/10ps
module fbg_guard (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [fbg_pkg::FBG_PC_W-1:0] i_pc,
  input wire logic [fbg_pkg::FBG_Z_W-1:0] i_zptr,
  input wire logic i_spm_req,
  input wire logic i_lpm_req,
  input wire logic [15:0] i_flash_word,
  output logic o_spm_done,
  output logic o_spm_ok,
  output logic [fbg_pkg::FBG_PAGE_W-1:0] o_page_sel,
  output logic [fbg_pkg::FBG_WORD_W-1:0] o_word_sel,
  output logic o_excl_region,
  output logic o_lpm_done,
  output logic [7:0] o_lpm_byte,
  output logic o_irq_off,
  output logic [fbg_pkg::FBG_PC_W-1:0] o_boot_start,
  input wire logic i_prog_wr_req,
  input wire logic i_prog_rd_req,
  input wire logic i_prog_fuse_req,
  output logic o_prog_wr_ok,
  output logic o_prog_rd_ok,
  output logic o_prog_fuse_ok
);
  import fbg_pkg::*;

  fbg_main_s s_r;
  fbg_main_s s_nxt;
  logic [FBG_LOCK_W-1:0] lock;
  logic lock_we;
  logic erase_go;
  logic [FBG_PC_W-1:0] boot_start;
  logic [FBG_PC_W-1:0] tgt;
  logic boot_frozen;
  logic fuse_free;
  logic addr_ph;

  // Boot reset address for a size setting; the section always runs up to the top word.
  function automatic logic [FBG_PC_W-1:0] boot_start_of(input logic [1:0] sz);
    logic [FBG_PC_W-1:0] a;
    a = FBG_BOOT_START_00;
    unique case (sz)
      2'h3: a = FBG_BOOT_START_11;
      2'h2: a = FBG_BOOT_START_10;
      2'h1: a = FBG_BOOT_START_01;
      2'h0: a = FBG_BOOT_START_00;
    endcase
    return a;
  endfunction : boot_start_of

  // Word address inside the boot section; everything below lies in the application section.
  function automatic logic in_boot(input logic [FBG_PC_W-1:0] a, input logic [FBG_PC_W-1:0] bs);
    return (a >= bs) && (a <= FBG_FLASH_TOP);
  endfunction : in_boot

  assign boot_start = boot_start_of(s_r.bootsz);
  // Pointer bit 0 is dropped, so the target is a word address.
  assign tgt = i_zptr[FBG_Z_W-1:FBG_Z_WORD_LSB];
  assign boot_frozen = !lock[FBG_LK_GEN_HI] && !lock[FBG_LK_GEN_LO];
  assign fuse_free = lock[FBG_LK_GEN_LO];
  assign addr_ph = i_hsel && i_htrans[1] && i_hready;

  // Register file decode, bus side.
  function automatic logic [31:0] reg_read(input logic [FBG_IDX_W-1:0] idx, input fbg_main_s st,
                                           input logic [FBG_LOCK_W-1:0] lk, input logic [FBG_PC_W-1:0] bs);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (idx == FBG_OFS_CFG[FBG_IDX_W+1:2]) begin
      d[FBG_CFG_SZ_HI:FBG_CFG_SZ_LO] = st.bootsz;
      d[FBG_CFG_IVSEL] = st.ivsel;
    end else if (idx == FBG_OFS_LOCK[FBG_IDX_W+1:2]) begin
      d[7:0] = {FBG_LK_UNUSED, lk};
    end else if (idx == FBG_OFS_STAT[FBG_IDX_W+1:2]) begin
      d[FBG_PC_W-1:0] = bs;
    end
    return d;
  endfunction : reg_read

  always_comb begin
    s_nxt = s_r;
    s_nxt.spm_done = 1'b0;
    s_nxt.lpm_done = 1'b0;
    s_nxt.wr_pend = 1'b0;
    lock_we = 1'b0;
    erase_go = 1'b0;

    if (addr_ph) begin
      // Decode above the index bits too, so aliases read as zero and ignore writes.
      s_nxt.wr_pend = i_hwrite && (i_haddr[31:FBG_IDX_W+2] == '0);
      s_nxt.wr_idx = i_haddr[FBG_IDX_W+1:2];
      s_nxt.rdata = (i_haddr[31:FBG_IDX_W+2] == '0) ?
                    reg_read(i_haddr[FBG_IDX_W+1:2], s_r, lock, boot_start) : 32'h0000_0000;
    end

    if (s_r.wr_pend) begin
      if (s_r.wr_idx == FBG_OFS_CFG[FBG_IDX_W+1:2] && fuse_free) begin
        // The size bits act as fuses, so they freeze with the general low lock bit.
        s_nxt.bootsz = i_hwdata[FBG_CFG_SZ_HI:FBG_CFG_SZ_LO];
        s_nxt.ivsel = i_hwdata[FBG_CFG_IVSEL];
      end
      lock_we = (s_r.wr_idx == FBG_OFS_LOCK[FBG_IDX_W+1:2]);
      erase_go = (s_r.wr_idx == FBG_OFS_ERASE[FBG_IDX_W+1:2]) && i_hwdata[FBG_ERASE_GO];
    end

    if (i_spm_req) begin
      s_nxt.spm_done = 1'b1;
      // A blocked store is simply not granted; nothing else reports it.
      s_nxt.spm_ok = in_boot(tgt, boot_start) ? lock[FBG_LK_BOOT_WR] : lock[FBG_LK_APP_WR];
      s_nxt.page = i_zptr[FBG_Z_W-1:FBG_Z_PAGE_LSB];
      // The core must hold this field at zero for a page write; it is passed on unchanged.
      s_nxt.word = i_zptr[FBG_Z_PAGE_LSB-1:FBG_Z_WORD_LSB];
      s_nxt.excl = (tgt >= FBG_EXCL_LO) && (tgt <= FBG_EXCL_HI);
    end

    if (i_lpm_req) begin
      s_nxt.lpm_done = 1'b1;
      if (in_boot(i_pc, boot_start) && !in_boot(tgt, boot_start) && !lock[FBG_LK_APP_RD]) begin
        s_nxt.lpm_byte = FBG_BLOCKED_BYTE;
      end else if (!in_boot(i_pc, boot_start) && in_boot(tgt, boot_start) && !lock[FBG_LK_BOOT_RD]) begin
        s_nxt.lpm_byte = FBG_BLOCKED_BYTE;
      end else begin
        s_nxt.lpm_byte = i_zptr[FBG_Z_BYTE_SEL] ? i_flash_word[15:8] : i_flash_word[7:0];
      end
    end

    // The executing section is found from the program counter against the boot start.
    s_nxt.irq_off = (!lock[FBG_LK_APP_RD] && s_r.ivsel && !in_boot(i_pc, boot_start)) ||
                    (!lock[FBG_LK_BOOT_RD] && !s_r.ivsel && in_boot(i_pc, boot_start));
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_r <= '{bootsz: FBG_BOOTSZ_RST, ivsel: FBG_IVSEL_RST, lpm_byte: FBG_BLOCKED_BYTE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  fbg_lock_store u_lock (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_prog_we(lock_we),
    .i_prog_data(i_hwdata[FBG_LOCK_W-1:0]),
    .i_boot_frozen(boot_frozen),
    .i_chip_erase(erase_go),
    .o_lock(lock)
  );

  // Programmer grants. The general bits may always be programmed further, as the store ANDs.
  assign o_prog_wr_ok = i_prog_wr_req && lock[FBG_LK_GEN_LO];
  assign o_prog_rd_ok = i_prog_rd_req && !boot_frozen;
  assign o_prog_fuse_ok = i_prog_fuse_req && fuse_free;

  assign o_hrdata = s_r.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_spm_done = s_r.spm_done;
  assign o_spm_ok = s_r.spm_ok;
  assign o_page_sel = s_r.page;
  assign o_word_sel = s_r.word;
  assign o_excl_region = s_r.excl;
  assign o_lpm_done = s_r.lpm_done;
  assign o_lpm_byte = s_r.lpm_byte;
  assign o_irq_off = s_r.irq_off;
  assign o_boot_start = boot_start;

  // Every check here runs on the one clock and rests while reset is held.
  default clocking chk_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Requests and running states whose outcome hangs on a guard bit, and the steady guard state.
  sequence app_store_s;
    i_spm_req && !in_boot(tgt, boot_start) && !lock[FBG_LK_APP_WR];
  endsequence

  sequence boot_store_s;
    i_spm_req && in_boot(tgt, boot_start) && !lock[FBG_LK_BOOT_WR];
  endsequence

  sequence open_store_s;
    i_spm_req && (in_boot(tgt, boot_start) ? lock[FBG_LK_BOOT_WR] : lock[FBG_LK_APP_WR]);
  endsequence

  sequence cross_load_s;
    i_lpm_req && !in_boot(i_pc, boot_start) && in_boot(tgt, boot_start) && !lock[FBG_LK_BOOT_RD];
  endsequence

  sequence app_read_s;
    i_lpm_req && in_boot(i_pc, boot_start) && !in_boot(tgt, boot_start) && !lock[FBG_LK_APP_RD];
  endsequence

  sequence boot_run_masked_s;
    !lock[FBG_LK_BOOT_RD] && !s_r.ivsel && in_boot(i_pc, boot_start);
  endsequence

  sequence app_run_masked_s;
    !lock[FBG_LK_APP_RD] && s_r.ivsel && !in_boot(i_pc, boot_start);
  endsequence

  sequence guard_steady_s;
    $stable(lock) && !$changed(s_r.ivsel);
  endsequence

  boot_size_11_a: assert property (
    s_r.bootsz == 2'h3 |-> boot_start == 15'h7E00
  ) else $error("boot start wrong for size 11");

  boot_size_10_a: assert property (
    s_r.bootsz == 2'h2 |-> boot_start == 15'h7C00
  ) else $error("boot start wrong for size 10");

  boot_size_01_a: assert property (
    s_r.bootsz == 2'h1 |-> boot_start == 15'h7800
  ) else $error("boot start wrong for size 01");

  boot_size_00_a: assert property (
    s_r.bootsz == 2'h0 |-> boot_start == 15'h7000
  ) else $error("boot start wrong for size 00");

  app_store_block_a: assert property (
    app_store_s |=> o_spm_done && !o_spm_ok
  ) else $error("store into guarded application passed");

  boot_store_block_a: assert property (
    boot_store_s |=> o_spm_done && !o_spm_ok
  ) else $error("store into guarded boot passed");

  open_store_pass_a: assert property (
    open_store_s |=> o_spm_done && o_spm_ok
  ) else $error("unguarded store refused");

  spm_quiet_a: assert property (
    !i_spm_req |=> !o_spm_done
  ) else $error("store answer without request");

  cross_load_block_a: assert property (
    cross_load_s |=> o_lpm_done && o_lpm_byte == 8'hFF
  ) else $error("guarded boot read leaked");

  app_read_block_a: assert property (
    app_read_s |=> o_lpm_done && o_lpm_byte == 8'hFF
  ) else $error("guarded application read leaked");

  lpm_quiet_a: assert property (
    !i_lpm_req |=> !o_lpm_done
  ) else $error("load answer without request");

  page_split_a: assert property (
    i_spm_req |=> o_page_sel == $past(i_zptr[15:8]) && o_word_sel == $past(i_zptr[7:1])
  ) else $error("pointer split wrong");

  excl_region_a: assert property (
    i_spm_req && i_zptr[15:12] == 4'h7 |=> o_excl_region
  ) else $error("exclusive region missed");

  rww_region_a: assert property (
    i_spm_req && i_zptr[15:12] != 4'h7 |=> !o_excl_region
  ) else $error("concurrent region marked exclusive");

  byte_select_a: assert property (
    i_lpm_req && in_boot(i_pc, boot_start) == in_boot(tgt, boot_start) && i_zptr[0]
    |=> o_lpm_byte == $past(i_flash_word[15:8])
  ) else $error("high byte not selected");

  byte_low_a: assert property (
    i_lpm_req && in_boot(i_pc, boot_start) == in_boot(tgt, boot_start) && !i_zptr[0]
    |=> o_lpm_byte == $past(i_flash_word[7:0])
  ) else $error("low byte not selected");

  fuse_freeze_a: assert property (
    !lock[FBG_LK_GEN_LO] && !erase_go |=> $stable(s_r.bootsz) [*2]
  ) else $error("size bits changed while locked");

  verify_block_a: assert property (
    boot_frozen |-> !o_prog_rd_ok && !o_prog_wr_ok
  ) else $error("verify allowed in full lock");

  prog_open_a: assert property (
    lock[1:0] == 2'h3 |-> o_prog_wr_ok == i_prog_wr_req && o_prog_rd_ok == i_prog_rd_req
      && o_prog_fuse_ok == i_prog_fuse_req
  ) else $error("programmer limited with general bits clear");

  prog_stop_a: assert property (
    !lock[FBG_LK_GEN_LO] |-> !o_prog_wr_ok && !o_prog_fuse_ok
  ) else $error("programming allowed with general low bit set");

  verify_kept_a: assert property (
    lock[1:0] == 2'h2 |-> o_prog_rd_ok == i_prog_rd_req
  ) else $error("verify refused with only general low bit set");

  irq_mask_a: assert property (
    boot_run_masked_s ##1 guard_steady_s |-> o_irq_off
  ) else $error("interrupts not masked in boot code");

  irq_app_mask_a: assert property (
    app_run_masked_s ##1 guard_steady_s |-> o_irq_off
  ) else $error("interrupts not masked in application code");

  irq_free_a: assert property (
    lock[5:2] == 4'hF |=> !o_irq_off
  ) else $error("interrupts masked without read guard");

  lock_read_a: assert property (
    addr_ph && !i_hwrite && i_haddr == FBG_OFS_LOCK |=> o_hrdata[7:6] == 2'h3 && o_hrdata[31:8] == '0
  ) else $error("lock byte upper bits wrong");

  stat_read_a: assert property (
    addr_ph && !i_hwrite && i_haddr == FBG_OFS_STAT |=> o_hrdata == {17'h0_0000, $past(boot_start)}
  ) else $error("status read lost boot start");
endmodule : fbg_guard

// File: fbg_core_model.sv
// Behavioural model of the processor core and the external programmer that face the guard.
`timescale 1ns/10ps
module fbg_core_model (
  input wire logic i_clk,
  output logic [fbg_pkg::FBG_PC_W-1:0] o_pc,
  output logic [fbg_pkg::FBG_Z_W-1:0] o_zptr,
  output logic o_spm_req,
  output logic o_lpm_req,
  output logic [15:0] o_flash_word,
  output logic o_prog_wr_req,
  output logic o_prog_rd_req,
  output logic o_prog_fuse_req
);
  import fbg_pkg::*;
  initial begin
    o_pc = 15'h0000;
    o_zptr = 16'h0000;
    o_spm_req = 1'b0;
    o_lpm_req = 1'b0;
    o_flash_word = 16'h5A5A;
    o_prog_wr_req = 1'b0;
    o_prog_rd_req = 1'b0;
    o_prog_fuse_req = 1'b0;
  end
  // The top bit is set so that the two bytes of every word used here differ.
  function automatic logic [15:0] flash_at(input logic [FBG_PC_W-1:0] a);
    return {1'b1, a};
  endfunction : flash_at
  // The byte select stays clear on every store; the word field is driven as given.
  task automatic store(input logic [FBG_PAGE_W-1:0] page, input logic [FBG_WORD_W-1:0] word);
    o_zptr <= {page, word, 1'b0};
    o_spm_req <= 1'b1;
    @(posedge i_clk);
    o_spm_req <= 1'b0;
  endtask : store
  task automatic load(input logic [FBG_PC_W-1:0] pc, input logic [FBG_Z_W-1:0] z);
    o_pc <= pc;
    o_zptr <= z;
    o_flash_word <= flash_at(z[15:1]);
    o_lpm_req <= 1'b1;
    @(posedge i_clk);
    o_lpm_req <= 1'b0;
    // The flash output is not held after the load, so a stale word cannot pass for a good one.
    o_flash_word <= ~flash_at(z[15:1]);
  endtask : load
  task automatic set_pc(input logic [FBG_PC_W-1:0] pc);
    o_pc <= pc;
  endtask : set_pc
  task automatic prog(input logic wr, input logic rd, input logic fuse);
    o_prog_wr_req <= wr;
    o_prog_rd_req <= rd;
    o_prog_fuse_req <= fuse;
  endtask : prog
endmodule : fbg_core_model

// File: tb.sv
// Self-checking testbench of the flash boot partition guard driven through its bus and core model.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  import fbg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, spm_done, spm_ok, excl, lpm_done, irq_off, wr_ok, rd_ok, fuse_ok;
  logic [7:0] page_sel, lpm_byte;
  logic [6:0] word_sel;
  logic [14:0] boot_start, pc;
  logic [15:0] zptr, fword;
  logic spm_req, lpm_req, pwr, prd, pfuse;
  logic [14:0] starts [4] = '{15'h7000, 15'h7800, 15'h7C00, 15'h7E00};
  logic [14:0] ex_t [4] = '{15'h37FF, 15'h3800, 15'h3FFF, 15'h4000};
  logic ex_e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  fbg_core_model core (.i_clk(clk), .o_pc(pc), .o_zptr(zptr), .o_spm_req(spm_req), .o_lpm_req(lpm_req),
    .o_flash_word(fword), .o_prog_wr_req(pwr), .o_prog_rd_req(prd), .o_prog_fuse_req(pfuse));
  fbg_guard dut (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
    .o_hreadyout(hreadyout), .o_hresp(hresp), .i_pc(pc), .i_zptr(zptr), .i_spm_req(spm_req),
    .i_lpm_req(lpm_req), .i_flash_word(fword), .o_spm_done(spm_done), .o_spm_ok(spm_ok),
    .o_page_sel(page_sel), .o_word_sel(word_sel), .o_excl_region(excl), .o_lpm_done(lpm_done),
    .o_lpm_byte(lpm_byte), .o_irq_off(irq_off), .o_boot_start(boot_start), .i_prog_wr_req(pwr),
    .i_prog_rd_req(prd), .i_prog_fuse_req(pfuse), .o_prog_wr_ok(wr_ok), .o_prog_rd_ok(rd_ok),
    .o_prog_fuse_ok(fuse_ok));
  task automatic print_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict;
    end
  end
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, q)
  endtask : rd_chk
  task automatic store_chk(input logic [14:0] t, input logic e_ok, input logic e_excl);
    core.store(t[14:7], t[6:0]);
    @(negedge clk);
    `CHK("spm_done", 1'b1, spm_done)
    `CHK("spm_ok", e_ok, spm_ok)
    `CHK("page_sel", t[14:7], page_sel)
    `CHK("word_sel", t[6:0], word_sel)
    `CHK("excl_region", e_excl, excl)
    @(negedge clk);
    `CHK("spm_done_end", 1'b0, spm_done)
    @(posedge clk);
  endtask : store_chk
  task automatic load_chk(input logic [14:0] p, input logic [15:0] z, input logic blocked);
    core.load(p, z);
    @(negedge clk);
    `CHK("lpm_done", 1'b1, lpm_done)
    `CHK("lpm_byte", blocked ? 8'hFF : (z[0] ? {1'b1, z[15:9]} : z[8:1]), lpm_byte)
    @(posedge clk);
  endtask : load_chk
  task automatic irq_chk(input logic [14:0] p, input logic e);
    core.set_pc(p);
    @(posedge clk);
    @(negedge clk);
    `CHK("irq_off", e, irq_off)
    @(posedge clk);
  endtask : irq_chk
  task automatic prog_chk(input logic ew, input logic er, input logic ef);
    core.prog(1'b1, 1'b1, 1'b1);
    @(negedge clk);
    `CHK("prog_wr_ok", ew, wr_ok)
    `CHK("prog_rd_ok", er, rd_ok)
    `CHK("prog_fuse_ok", ef, fuse_ok)
    @(posedge clk);
  endtask : prog_chk
  task automatic scn_sizes;
    wr(FBG_OFS_LOCK, 32'h2F);
    for (int i = 0; i < 4; i++) begin
      wr(FBG_OFS_CFG, 32'(i));
      rd_chk("boot_start_reg", FBG_OFS_STAT, {17'h0, starts[i]});
      `CHK("boot_start", starts[i], boot_start)
      store_chk(starts[i] - 15'h1, 1'b1, 1'b0);
      store_chk(starts[i], 1'b0, 1'b0);
    end
    wr(FBG_OFS_ERASE, 32'h1);
  endtask : scn_sizes
  task automatic scn_store;
    for (int i = 0; i < 4; i++) begin
      store_chk(ex_t[i], 1'b1, ex_e[i]);
    end
    wr(FBG_OFS_LOCK, 32'h3B);
    wr(FBG_OFS_LOCK, 32'h3F);
    rd_chk("lock_no_set", FBG_OFS_LOCK, 32'hFB);
    store_chk(15'h7DFF, 1'b0, 1'b0);
    store_chk(15'h7E00, 1'b1, 1'b0);
    wr(FBG_OFS_ERASE, 32'h1);
    rd_chk("lock_erased", FBG_OFS_LOCK, 32'hFF);
  endtask : scn_store
  task automatic scn_load;
    wr(FBG_OFS_LOCK, 32'h37);
    load_chk(15'h7E00, {15'h0123, 1'b1}, 1'b1);
    load_chk(15'h0100, {15'h0123, 1'b1}, 1'b0);
    load_chk(15'h7E00, {15'h7F05, 1'b0}, 1'b0);
    wr(FBG_OFS_CFG, 32'h7);
    irq_chk(15'h0100, 1'b1);
    irq_chk(15'h7E00, 1'b0);
    wr(FBG_OFS_CFG, 32'h3);
    irq_chk(15'h0100, 1'b0);
    wr(FBG_OFS_ERASE, 32'h1);
    wr(FBG_OFS_LOCK, 32'h1F);
    load_chk(15'h0100, {15'h7F05, 1'b0}, 1'b1);
    load_chk(15'h7F00, {15'h7F05, 1'b1}, 1'b0);
    irq_chk(15'h7E10, 1'b1);
    irq_chk(15'h0100, 1'b0);
    wr(FBG_OFS_ERASE, 32'h1);
  endtask : scn_load
  task automatic scn_prog;
    // Boot lock bits go in before the general pair, which freezes them afterwards.
    wr(FBG_OFS_LOCK, 32'h2F);
    wr(FBG_OFS_LOCK, 32'h2E);
    prog_chk(1'b0, 1'b1, 1'b0);
    wr(FBG_OFS_CFG, 32'h0);
    rd_chk("cfg_frozen", FBG_OFS_CFG, 32'h3);
    wr(FBG_OFS_LOCK, 32'h2C);
    prog_chk(1'b0, 1'b0, 1'b0);
    wr(FBG_OFS_LOCK, 32'h00);
    rd_chk("boot_lock_frozen", FBG_OFS_LOCK, 32'hEC);
    wr(FBG_OFS_ERASE, 32'h1);
    prog_chk(1'b1, 1'b1, 1'b1);
  endtask : scn_prog
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk("cfg_rst", FBG_OFS_CFG, 32'h0);
    rd_chk("lock_rst", FBG_OFS_LOCK, 32'hFF);
    rd_chk("stat_rst", FBG_OFS_STAT, 32'h7000);
    rd_chk("unmapped", 32'h0000_0010, 32'h0);
    `CHK("hresp", 1'b0, hresp)
    prog_chk(1'b1, 1'b1, 1'b1);
    scn_sizes();
    scn_store();
    scn_load();
    scn_prog();
    print_verdict();
  end
endmodule : tb
